// File: rtl/flash_self_prog_ctrl.sv
// Function
// R1 - Store-program from application region is ignored, nothing starts.
// R2 - Erase or write starts only when issued from boot region.
// R3 - From boot region any page of whole flash may be targeted.
// R4 - Boot/application boundary follows the boot-size fuses.
// R5 - Application and boot regions have independent lock-bit sets.
// R6 - Fixed boundary splits flash into concurrent-read and halting regions.
// R7 - Operation classified by target page region, not fetch region.
// R8 - Concurrent-region operation keeps halting-region fetches flowing, no stall.
// R9 - Halting-region operation stalls CPU for the whole page operation.
// R10 - No valid code returned from concurrent region during programming.
// R11 - Busy flag reads one while concurrent region is blocked.
// R12 - Software clears busy flag before touching concurrent region again.
// R13 - Software disables or relocates interrupts while programming.
// R14 - Boot region always lies inside the halting region.
// R15 - Page organisation invisible to ordinary fetches and reads.
// R16 - Lock pair 1,0 blocks writes; 0,0 adds read block; 0,1 reads only.
// R17 - Lock bits programmable by software or programmer, cleared by chip erase.
// R18 - Stall released when halting-region operation finishes.
`timescale 1ns/10ps
`default_nettype none
module flash_self_prog_ctrl
  import flash_ctrl_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // Register port
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  // Fuses and programming-mode access to the lock bits
  input  wire logic [1:0]        boot_size_fuses_i,
  input  wire logic              pgm_lock_wr_i,
  input  wire logic [3:0]        pgm_lock_data_i,
  input  wire logic              chip_erase_i,
  // Store-program instruction from the core
  input  wire logic              store_req_i,
  input  wire logic [13:0]       store_pc_i,
  input  wire logic [13:0]       store_addr_i,
  // Code fetch and load-program read from the core
  input  wire logic              fetch_req_i,
  input  wire logic              fetch_is_load_i,
  input  wire logic [13:0]       fetch_pc_i,
  input  wire logic [13:0]       fetch_addr_i,
  output logic                   fetch_valid_o,
  output logic                   fetch_blocked_o,
  output logic                   cpu_stall_o,
  // Flash array
  output logic                   flash_start_o,
  output logic      [1:0]        flash_cmd_o,
  output logic      [7:0]        flash_page_o,
  input  wire logic              flash_done_i,
  // Interrupt
  output logic                   irq_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_RWW_OP, ST_HALT_OP} state_t;

  state_t      state_ff;
  state_t      nxt_state;
  logic        busy_ff;
  logic        op_write_ff;
  logic        start_ff;
  logic [1:0]  cmd_ff;
  logic [7:0]  page_ff;
  logic        stall_ff;
  logic        fvalid_ff;
  logic        fblock_ff;
  logic [1:0]  int_stat_ff;
  logic [1:0]  int_mask_ff;
  logic        irq_ff;
  logic [7:0]  rdata_ff;

  logic        pc_in_boot;
  logic        tgt_in_boot;
  logic        tgt_in_halt;
  logic        f_in_boot;
  logic        f_in_halt;
  logic        fpc_in_boot;
  logic [1:0]  app_lock;
  logic [1:0]  boot_lock;
  logic        tgt_write_locked;
  logic        store_ok;
  logic        store_refused;
  logic        op_done;
  logic        cross_read_locked;
  logic        fetch_ok;
  logic        wr_csr;
  logic        wr_lock;
  logic        wr_stat;
  logic        wr_mask;
  logic [1:0]  ev_set;

  // Region decode of issuing address, target page and fetch address
  flash_region_map u_map_pc (
    .addr_i            (store_pc_i),
    .boot_size_fuses_i (boot_size_fuses_i),
    .in_boot_o         (pc_in_boot),
    .in_halting_o      ()
  );

  flash_region_map u_map_tgt (
    .addr_i            (store_addr_i),
    .boot_size_fuses_i (boot_size_fuses_i),
    .in_boot_o         (tgt_in_boot),
    .in_halting_o      (tgt_in_halt)
  );

  flash_region_map u_map_fetch (
    .addr_i            (fetch_addr_i),
    .boot_size_fuses_i (boot_size_fuses_i),
    .in_boot_o         (f_in_boot),
    .in_halting_o      (f_in_halt)
  );

  flash_region_map u_map_fpc (
    .addr_i            (fetch_pc_i),
    .boot_size_fuses_i (boot_size_fuses_i),
    .in_boot_o         (fpc_in_boot),
    .in_halting_o      ()
  );

  // Register write decode
  always_comb begin
    wr_csr  = reg_wr_i && (reg_addr_i == OFS_CSR);
    wr_lock = reg_wr_i && (reg_addr_i == OFS_LOCK);
    wr_stat = reg_wr_i && (reg_addr_i == OFS_INT_STAT);
    wr_mask = reg_wr_i && (reg_addr_i == OFS_INT_MASK);
  end

  // Lock bits, separate sets for the two regions
  flash_lock_store u_locks (
    .clk_i                   (clk_i),
    .resetn_i                (resetn_i),
    .sw_wr_i                 (wr_lock),
    .sw_data_i               (reg_wdata_i[3:0]),
    .pgm_wr_i                (pgm_lock_wr_i),
    .pgm_data_i              (pgm_lock_data_i),
    .chip_erase_i            (chip_erase_i),
    .application_lock_bits_o (app_lock),
    .boot_lock_bits_o        (boot_lock)
  );

  // Write block when the low bit of the guarding pair is programmed
  always_comb begin
    if (tgt_in_boot) begin
      tgt_write_locked = !boot_lock[0];               // R16 R5
    end else begin
      tgt_write_locked = !app_lock[0];                // R16 R5
    end
  end

  // Store acceptance: boot-issued, idle, target not write-locked
  always_comb begin
    store_ok      = store_req_i && pc_in_boot         // R1 R2
                    && (state_ff == ST_IDLE)
                    && !tgt_write_locked;             // R3
    store_refused = store_req_i && !store_ok;         // R1
    op_done       = (state_ff != ST_IDLE) && flash_done_i;
  end

  // Sequencer; target region decides the operation kind
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (store_ok) begin
          if (tgt_in_halt) begin
            nxt_state = ST_HALT_OP;                   // R7 R9
          end else begin
            nxt_state = ST_RWW_OP;                    // R7 R8
          end
        end
      end
      ST_RWW_OP: begin
        if (flash_done_i) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_HALT_OP: begin
        if (flash_done_i) begin
          nxt_state = ST_IDLE;                        // R18
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // CPU stall follows the halting-region operation exactly
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      stall_ff <= 1'b0;
    end else begin
      stall_ff <= (nxt_state == ST_HALT_OP);          // R9 R18
    end
  end

  // Operation kind selected by software
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      op_write_ff <= 1'b0;
    end else if (wr_csr) begin
      op_write_ff <= reg_wdata_i[CSR_OP_WRITE];
    end
  end

  // Flash array start pulse, command and page of the target
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      start_ff <= 1'b0;
      cmd_ff   <= CMD_NONE;
      page_ff  <= 8'h00;
    end else begin
      start_ff <= store_ok;
      if (store_ok) begin
        cmd_ff  <= op_write_ff ? CMD_WRITE : CMD_ERASE;
        page_ff <= store_addr_i[FLASH_AW-1:PAGE_LSB]; // R15
      end else if (op_done) begin
        cmd_ff  <= CMD_NONE;
      end
    end
  end

  // Busy flag: set on concurrent-region start, kept until software clears
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      busy_ff <= 1'b0;
    end else if (store_ok && !tgt_in_halt) begin
      busy_ff <= 1'b1;                                // R11
    end else if (wr_csr && reg_wdata_i[CSR_BUSY] && (state_ff != ST_RWW_OP)) begin
      busy_ff <= 1'b0;                                // R12
    end
  end

  // Cross-region load reads guarded by the high bit of the pair
  always_comb begin
    cross_read_locked = 1'b0;
    if (fetch_is_load_i) begin
      if (fpc_in_boot && !f_in_boot) begin
        cross_read_locked = !app_lock[1];             // R16
      end else if (!fpc_in_boot && f_in_boot) begin
        cross_read_locked = !boot_lock[1];            // R16
      end
    end
  end

  // Fetch admission; halting region keeps serving during concurrent work
  always_comb begin
    fetch_ok = 1'b1;
    if (state_ff == ST_HALT_OP) begin
      fetch_ok = 1'b0;                                // R9
    end else if (busy_ff && !f_in_halt) begin
      fetch_ok = 1'b0;                                // R10 R11
    end else if (cross_read_locked) begin
      fetch_ok = 1'b0;
    end
  end

  // Fetch answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      fvalid_ff <= 1'b0;
      fblock_ff <= 1'b0;
    end else begin
      fvalid_ff <= fetch_req_i && fetch_ok;           // R8 R15
      fblock_ff <= fetch_req_i && !fetch_ok;          // R10
    end
  end

  // Interrupt events; a set beats a simultaneous clear
  always_comb begin
    ev_set             = 2'h0;
    ev_set[EV_DONE]    = op_done;
    ev_set[EV_REFUSED] = store_refused;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      int_stat_ff <= INT_RST;
    end else begin
      int_stat_ff <= (int_stat_ff & ~(wr_stat ? reg_wdata_i[1:0] : 2'h0)) | ev_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      int_mask_ff <= INT_RST;
    end else if (wr_mask) begin
      int_mask_ff <= reg_wdata_i[1:0];
    end
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |((int_stat_ff | ev_set) & int_mask_ff
                  & ~(wr_stat ? reg_wdata_i[1:0] & ~ev_set : 2'h0));
    end
  end

  // Register read, data valid in the following cycle only
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_CSR: begin
          rdata_ff               <= 8'h00;
          rdata_ff[CSR_OP_WRITE] <= op_write_ff;
          rdata_ff[CSR_HALTED]   <= (state_ff == ST_HALT_OP);
          rdata_ff[CSR_BUSY]     <= busy_ff;          // R11
        end
        OFS_LOCK:     rdata_ff <= {4'h0, boot_lock, app_lock};
        OFS_INT_STAT: rdata_ff <= {6'h00, int_stat_ff};
        OFS_INT_MASK: rdata_ff <= {6'h00, int_mask_ff};
        default:      rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_o     = rdata_ff;
  assign fetch_valid_o   = fvalid_ff;
  assign fetch_blocked_o = fblock_ff;
  assign cpu_stall_o     = stall_ff;
  assign flash_start_o   = start_ff;
  assign flash_cmd_o     = cmd_ff;
  assign flash_page_o    = page_ff;
  assign irq_o           = irq_ff;

endmodule
`default_nettype wire

// File: shared/flash_ctrl_pkg.sv
package flash_ctrl_pkg;

  // Flash geometry, word addressed
  localparam int unsigned FLASH_AW   = 14;
  localparam int unsigned PAGE_LSB   = 6;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned REG_AW     = 4;

  // Fixed concurrent-read / halting split
  localparam logic [13:0] HALT_BASE  = 14'h3800;

  // Boot region base per boot-size fuse setting
  localparam logic [13:0] BOOT_BASE_3 = 14'h3f00;
  localparam logic [13:0] BOOT_BASE_2 = 14'h3e00;
  localparam logic [13:0] BOOT_BASE_1 = 14'h3c00;
  localparam logic [13:0] BOOT_BASE_0 = 14'h3800;

  // Register offsets
  localparam logic [3:0] OFS_CSR      = 4'h0;
  localparam logic [3:0] OFS_LOCK     = 4'h1;
  localparam logic [3:0] OFS_INT_STAT = 4'h2;
  localparam logic [3:0] OFS_INT_MASK = 4'h3;

  // Control and status field positions
  localparam int unsigned CSR_OP_WRITE = 0;
  localparam int unsigned CSR_HALTED   = 1;
  localparam int unsigned CSR_BUSY     = 6;

  // Interrupt event positions
  localparam int unsigned EV_DONE    = 0;
  localparam int unsigned EV_REFUSED = 1;

  // Reset values
  localparam logic [3:0] LOCK_RST    = 4'hf;
  localparam logic [1:0] INT_RST     = 2'h0;

  // Flash array commands
  typedef enum logic [1:0] {CMD_NONE, CMD_ERASE, CMD_WRITE} flash_cmd_t;

  // Start of the boot region from the boot-size fuses
  function automatic logic [13:0] boot_base(input logic [1:0] fuses);
    case (fuses)
      2'h3:    boot_base = BOOT_BASE_3;
      2'h2:    boot_base = BOOT_BASE_2;
      2'h1:    boot_base = BOOT_BASE_1;
      default: boot_base = BOOT_BASE_0;
    endcase
  endfunction

endpackage

// File: rtl/flash_region_map.sv
`timescale 1ns/10ps
`default_nettype none
module flash_region_map
  import flash_ctrl_pkg::*;
(
  input  wire logic [13:0] addr_i,
  input  wire logic [1:0]  boot_size_fuses_i,
  output logic             in_boot_o,
  output logic             in_halting_o
);

  // Fuse-sized split and fixed split are decoded independently
  always_comb begin
    in_boot_o    = (addr_i >= boot_base(boot_size_fuses_i)); // R4 R14
    in_halting_o = (addr_i >= HALT_BASE);                    // R6
  end

endmodule
`default_nettype wire

// File: rtl/flash_lock_store.sv
`timescale 1ns/10ps
`default_nettype none
module flash_lock_store
  import flash_ctrl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       sw_wr_i,
  input  wire logic [3:0] sw_data_i,
  input  wire logic       pgm_wr_i,
  input  wire logic [3:0] pgm_data_i,
  input  wire logic       chip_erase_i,
  output logic [1:0]      application_lock_bits_o,
  output logic [1:0]      boot_lock_bits_o
);

  logic [3:0] lock_ff;

  // Writes may only program bits (1 to 0); only chip erase or reset restores ones
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      lock_ff <= LOCK_RST;
    end else if (chip_erase_i) begin
      lock_ff <= LOCK_RST;                            // R17
    end else begin
      lock_ff <= lock_ff
                 & (sw_wr_i  ? sw_data_i  : 4'hf)
                 & (pgm_wr_i ? pgm_data_i : 4'hf);    // R17
    end
  end

  // Two independent sets
  assign application_lock_bits_o = lock_ff[1:0];      // R5
  assign boot_lock_bits_o        = lock_ff[3:2];      // R5

endmodule
`default_nettype wire

// File: sim/flash_self_prog_checker.sv
`timescale 1ns/10ps
`default_nettype none
module flash_self_prog_checker
  import flash_ctrl_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        store_req_i,
  input wire logic [13:0] store_pc_i,
  input wire logic [13:0] store_addr_i,
  input wire logic        fetch_req_i,
  input wire logic [13:0] fetch_addr_i,
  input wire logic        fetch_valid_o,
  input wire logic        fetch_blocked_o,
  input wire logic        cpu_stall_o,
  input wire logic        flash_start_o,
  input wire logic [7:0]  flash_page_o,
  input wire logic        flash_done_i
);
  localparam logic [7:0] HALT_PG = HALT_BASE[13:6];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic conc_ff;
  // Concurrent-region op in flight
  always_ff @(posedge clk_i) begin
    if (!resetn_i || flash_done_i) begin
      conc_ff <= 1'b0;
    end else if (flash_start_o && flash_page_o < HALT_PG) begin
      conc_ff <= 1'b1;
    end
  end
  property p_app_ignored;
    store_req_i && store_pc_i < HALT_BASE |=> !flash_start_o;
  endproperty
  property p_start_cause;
    flash_start_o |-> $past(store_req_i) && $past(store_pc_i) >= HALT_BASE;
  endproperty
  property p_page;
    flash_start_o |-> flash_page_o == $past(store_addr_i[13:6]);
  endproperty
  property p_halt_stall;
    flash_start_o && flash_page_o >= HALT_PG |-> cpu_stall_o;
  endproperty
  property p_conc_run;
    flash_start_o && flash_page_o < HALT_PG |-> !cpu_stall_o;
  endproperty
  property p_stall_hold;
    cpu_stall_o && !flash_done_i |=> cpu_stall_o;
  endproperty
  property p_release;
    cpu_stall_o && flash_done_i |=> !cpu_stall_o;
  endproperty
  property p_answer;
    fetch_req_i |=> fetch_valid_o != fetch_blocked_o;
  endproperty
  property p_halt_block;
    cpu_stall_o && !flash_done_i && fetch_req_i |=> fetch_blocked_o;
  endproperty
  property p_conc_block;
    conc_ff && fetch_req_i && fetch_addr_i < HALT_BASE |=> fetch_blocked_o;
  endproperty
  a_app_ignored: assert property (p_app_ignored) else $error("start from app pc");
  a_start_cause: assert property (p_start_cause) else $error("start without boot store");
  a_page: assert property (p_page) else $error("wrong page");
  a_halt_stall: assert property (p_halt_stall) else $error("no stall");
  a_conc_run: assert property (p_conc_run) else $error("stall on concurrent op");
  a_stall_hold: assert property (p_stall_hold) else $error("stall dropped early");
  a_release: assert property (p_release) else $error("stall not released");
  a_answer: assert property (p_answer) else $error("fetch answer wrong");
  a_halt_block: assert property (p_halt_block) else $error("fetch served in halt");
  a_conc_block: assert property (p_conc_block) else $error("blocked region served");
  c_halt: cover property (flash_start_o && cpu_stall_o);
  c_conc: cover property (conc_ff && fetch_valid_o);
  c_release: cover property (cpu_stall_o && flash_done_i);
endmodule
`default_nettype wire

// File: sim/flash_array_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       flash_start_i,
  input  wire logic [7:0] lat_i,
  output logic            flash_done_o
);
  logic [7:0] cnt_ff;
  // Page op takes lat_i cycles, then one done pulse
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_ff       <= 8'h0;
      flash_done_o <= 1'b0;
    end else begin
      flash_done_o <= 1'b0;
      if (flash_start_i) begin
        cnt_ff <= lat_i;
      end else if (cnt_ff != 8'h0) begin
        cnt_ff <= cnt_ff - 8'h1;
        flash_done_o <= (cnt_ff == 8'h1);
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/tb_flash_self_prog_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_flash_self_prog_ctrl;
  import flash_ctrl_pkg::*;
  logic clk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0, pgm_lock_wr_i = 0;
  logic chip_erase_i = 0, store_req_i = 0, fetch_req_i = 0, fetch_is_load_i = 0;
  logic [3:0] reg_addr_i = 4'h0, pgm_lock_data_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h0, reg_rdata_o, flash_page_o, lat = 8'h14;
  logic [1:0] boot_size_fuses_i = 2'h3, flash_cmd_o;
  logic [13:0] store_pc_i = 14'h0, store_addr_i = 14'h0, fetch_pc_i = 14'h0;
  logic [13:0] fetch_addr_i = 14'h0;
  logic fetch_valid_o, fetch_blocked_o, cpu_stall_o, flash_start_o, flash_done_i, irq_o;
  int fail_count = 0, check_count = 0;
  logic [7:0] d;
  always #25 clk_i = ~clk_i;
  flash_self_prog_ctrl dut (.*);
  flash_array_model fm (.clk_i, .resetn_i, .flash_start_i(flash_start_o), .lat_i(lat),
    .flash_done_o(flash_done_i));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clk_i);
    reg_rd_i <= 1; reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 0;
    #1 d = reg_rdata_o;
  endtask
  task automatic store(logic [13:0] pc, logic [13:0] ad);
    @(posedge clk_i);
    store_req_i <= 1; store_pc_i <= pc; store_addr_i <= ad;
    @(posedge clk_i);
    store_req_i <= 0;
    #1;
  endtask
  task automatic fetch(logic ld, logic [13:0] pc, logic [13:0] ad, logic [1:0] e, string n);
    @(posedge clk_i);
    fetch_req_i <= 1; fetch_is_load_i <= ld; fetch_pc_i <= pc; fetch_addr_i <= ad;
    @(posedge clk_i);
    fetch_req_i <= 0;
    #1 chk(n, e, {fetch_valid_o, fetch_blocked_o});
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 200 && flash_cmd_o !== 2'h0; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (i == 200) begin
      fail_count++;
      print_verdict();
    end
    #1;
  endtask
  // Reset values and unmapped offset
  task automatic t_reset();
    rd(OFS_LOCK); chk("lock", {12'h0, LOCK_RST}, d);
    rd(OFS_INT_STAT); chk("stat", 0, d);
    rd(4'hf); chk("unmapped", 0, d);
    wr(4'hf, 8'hff); rd(OFS_INT_MASK); chk("mask", 0, d);
  endtask
  // Store from application code is refused
  task automatic t_app();
    store(14'h0100, 14'h3f80); chk("app start", 0, flash_start_o);
    rd(OFS_INT_STAT); chk("refused", 2, d);
    chk("irq masked", 0, irq_o);
    wr(OFS_INT_STAT, 8'h02);
  endtask
  // Boot page write halts CPU until done
  task automatic t_halt();
    wr(OFS_INT_MASK, 8'h01); wr(OFS_CSR, 8'h01);
    store(14'h3f10, 14'h3f80);
    chk("start", 16'h6fe, {flash_start_o, flash_cmd_o, flash_page_o});
    chk("stall", 1, cpu_stall_o);
    fetch(0, 14'h3f10, 14'h3f20, 2'b01, "halt fetch");
    rd(OFS_CSR); chk("halted", 8'h03, d);
    wait_idle(); @(posedge clk_i); #1;
    chk("released", 0, cpu_stall_o);
    chk("irq", 1, irq_o);
    wr(OFS_INT_STAT, 8'h01); #1 chk("irq clr", 0, irq_o);
  endtask
  // Concurrent-region erase keeps halting region readable
  task automatic t_conc();
    lat = 8'h04;
    wr(OFS_INT_MASK, 8'h00);
    wr(OFS_CSR, 8'h00); store(14'h3f10, 14'h0040);
    chk("erase", 16'h501, {flash_start_o, flash_cmd_o, flash_page_o});
    chk("no stall", 0, cpu_stall_o);
    fetch(0, 14'h3f10, 14'h3900, 2'b10, "halt region");
    fetch(0, 14'h3f10, 14'h0100, 2'b01, "conc region");
    wait_idle(); chk("irq off", 0, irq_o);
    rd(OFS_CSR); chk("busy", 1, d[CSR_BUSY]);
    fetch(0, 14'h3f10, 14'h0100, 2'b01, "still blocked");
    wr(OFS_CSR, 8'h40); rd(OFS_CSR); chk("busy clr", 0, d[CSR_BUSY]);
    fetch(0, 14'h3f10, 14'h0100, 2'b10, "conc again");
    lat = 8'h14;
  endtask
  // Boot boundary follows the fuses
  task automatic t_fuse();
    boot_size_fuses_i <= 2'h3; store(14'h3c00, 14'h3c40);
    chk("fuse3", 0, flash_start_o);
    boot_size_fuses_i <= 2'h1; store(14'h3c00, 14'h3c40);
    chk("fuse1", 1, flash_start_o);
    wait_idle(); boot_size_fuses_i <= 2'h3;
  endtask
  // Independent lock pairs, clear only by chip erase
  task automatic t_lock();
    wr(OFS_LOCK, 8'h0c); store(14'h3f10, 14'h0040);
    chk("app locked", 0, flash_start_o);
    fetch(1, 14'h3f10, 14'h0100, 2'b01, "cross load");
    store(14'h3f10, 14'h3f80); chk("boot open", 1, flash_start_o);
    wait_idle();
    wr(OFS_LOCK, 8'h0f); rd(OFS_LOCK); chk("no clear", 8'h0c, d);
    @(posedge clk_i) chip_erase_i <= 1;
    @(posedge clk_i) chip_erase_i <= 0;
    rd(OFS_LOCK); chk("erased", 8'h0f, d);
    @(posedge clk_i) begin
      pgm_lock_wr_i <= 1; pgm_lock_data_i <= 4'hb;
    end
    @(posedge clk_i) pgm_lock_wr_i <= 0;
    store(14'h3f10, 14'h3f80); chk("boot locked", 0, flash_start_o);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1;
    t_reset(); t_app(); t_halt(); t_conc(); t_fuse(); t_lock();
    print_verdict();
  end
endmodule
bind flash_self_prog_ctrl flash_self_prog_checker chk_u (.clk_i, .resetn_i, .store_req_i,
  .store_pc_i, .store_addr_i, .fetch_req_i, .fetch_addr_i, .fetch_valid_o,
  .fetch_blocked_o, .cpu_stall_o, .flash_start_o, .flash_page_o, .flash_done_i);
`default_nettype wire
